// >>> explicit_exchange.sv
// explicit message exchange: fetches a request from host memory, sends it
// to a node, waits for the reply and stores it back in host memory
// assumes host memory, link and node tables all run on clk
//
// Behaviour
// (R1) request byte 0 macid, byte 1 service
// (R2) bytes 2,3 class id, low first
// (R3) bytes 4,5 instance id, low first
// (R4) byte 6 attribute, data from byte 7
// (R5) host loads total request byte count
// (R6) reply stored: count, macid, service
// (R7) good reply service equals request plus 0x80
// (R8) extra reply data follows service byte
// (R9) service 0x94 marks an error reply
// (R10) error reply: general byte 4, additional 5
// (R11) vendor error codes passed through unchanged
// (R12) nodes scanned in ascending macid order
// (R13) device and nodes share one bit rate
// (R14) every node has a unique macid
// (R15) poll send bit, validate registers, fetch
// (R16) check macid range, configured, online
// (R17) abort sets error bit plus complete
// (R18) oversize reply flags overrun, not stored
// (R19) even byte low half, odd high
`timescale 1ns/100ps
`default_nettype none
module explicit_exchange
  import explicit_exchange_pkg::*;
#(
  parameter int MEM_WORDS   = 4096,
  parameter int RX_DEPTH    = 256,
  parameter int TIMEOUT_CYC = REPLY_TIMEOUT_CYC
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 send_cmd,
  input  wire logic [15:0]          tx_buffer_start_reg,
  input  wire logic [15:0]          tx_byte_count_reg,
  input  wire logic [15:0]          rx_buffer_start_reg,
  input  wire logic [15:0]          rx_buffer_size_reg,
  output logic                      mem_req,
  output logic                      mem_we,
  output logic      [15:0]          mem_addr,
  output logic      [15:0]          mem_wdata,
  input  wire logic                 mem_ack,
  input  wire logic                 mem_err,
  input  wire logic [15:0]          mem_rdata,
  input  wire logic [MACID_LIMIT-1:0] node_configured,
  input  wire logic [MACID_LIMIT-1:0] node_online,
  output logic                      tx_valid,
  output logic      [7:0]           tx_data,
  output logic                      tx_last,
  input  wire logic                 tx_ready,
  input  wire logic                 rx_valid,
  input  wire logic [7:0]           rx_data,
  input  wire logic                 rx_last,
  input  wire logic [1:0]           bit_rate_sel,
  output logic      [1:0]           link_bit_rate,
  output logic      [5:0]           scan_macid,
  output logic                      scan_strobe,
  output logic                      xfer_done,
  output logic      [ERR_W-1:0]     xfer_error,
  output logic                      reply_error,
  output logic                      vendor_error,
  output logic      [7:0]           reply_macid,
  output logic      [7:0]           general_code,
  output logic      [7:0]           additional_code
);
  import explicit_exchange_pkg::*;

  localparam int RAW = $clog2(RX_DEPTH);
  localparam int TW  = $clog2(TIMEOUT_CYC + 1);
  localparam int PW  = $clog2(POLL_CYCLES + 1);

  typedef struct packed {
    state_t           st;
    logic             armed;
    logic             done;
    logic [ERR_W-1:0] err;
    logic             rerr;
    logic [PW-1:0]    poll;
    logic [TW-1:0]    tmo;
    logic [15:0]      idx;
    logic [15:0]      addr;
    logic [15:0]      wbuf;
    logic [7:0]       txb;
    logic [7:0]       svc;
    logic [7:0]       macid;
    logic [7:0]       rmac;
    logic [7:0]       rsvc;
    logic [7:0]       gen;
    logic [7:0]       add;
    logic [15:0]      ridx;
    logic             ovf;
    logic [7:0]       lo;
    logic [5:0]       scan;
    logic             sstb;
    logic [1:0]       rate;
  } regs_t;

  regs_t            r_q;
  regs_t            r_d;
  logic             poll_tick;
  logic             ram_we;
  logic [RAW-1:0]   ram_raddr;
  logic [7:0]       ram_rdata;
  logic [15:0]      tx_words;
  logic [15:0]      rx_words;
  logic [16:0]      rx_total;

  assign poll_tick = (r_q.poll == PW'(POLL_CYCLES - 1));
  assign tx_words  = 16'((17'(tx_byte_count_reg) + 17'h1) >> 1);
  assign rx_words  = 16'((17'(rx_buffer_size_reg) + 17'h1) >> 1);
  assign rx_total  = 17'(r_q.ridx) + RX_HDR_BYTES;
  assign ram_we    = (r_q.st == S_WAIT) && rx_valid
                     && (r_q.ridx < 16'(RX_DEPTH));
  assign ram_raddr = (r_q.st == S_RDLO) ? RAW'(r_q.idx)
                                        : RAW'(r_q.idx + 16'h1);

  reply_byte_ram #(
    .DEPTH (RX_DEPTH),
    .AW    (RAW)
  ) u_ram (
    .clk     (clk),
    .rst_n   (rst_n),
    .we      (ram_we),
    .waddr   (RAW'(r_q.ridx)),
    .wdata   (rx_data),
    .raddr   (ram_raddr),
    .rdata_q (ram_rdata)
  );

  always_comb begin
    r_d  = r_q;
    r_d.poll = poll_tick ? '0 : PW'(r_q.poll + 1'b1);
    r_d.sstb = 1'b0;
    r_d.rate = bit_rate_sel; // [R13]
    // walk macids upward one per poll period, flag configured ones
    if (poll_tick) begin
      r_d.scan = r_q.scan + 6'h1; // [R12]
      r_d.sstb = node_configured[r_q.scan + 6'h1]; // [R12]
    end
    case (r_q.st)
      S_IDLE: begin
        if (!send_cmd) begin
          r_d.armed = 1'b1;
        end else if (poll_tick && r_q.armed) begin // [R15]
          r_d.armed = 1'b0;
          r_d.done  = 1'b0;
          r_d.err   = '0;
          r_d.rerr  = 1'b0;
          r_d.st    = S_CHKREG;
        end
      end
      S_CHKREG: begin
        // request must at least hold macid and service bytes
        if (tx_byte_count_reg < REQ_MIN_BYTES // [R5]
            || 17'(tx_buffer_start_reg) + 17'(tx_words) > 17'(MEM_WORDS)
            || 17'(rx_buffer_size_reg) < RX_MIN_SIZE
            || 17'(rx_buffer_start_reg) + 17'(rx_words)
               > 17'(MEM_WORDS)) begin // [R15]
          r_d.err[ERR_ALLOC] = 1'b1; // [R17]
          r_d.st = S_DONE;
        end else begin
          r_d.addr = tx_buffer_start_reg;
          r_d.idx  = 16'h0;
          r_d.st   = S_FETCH; // [R15]
        end
      end
      S_FETCH: begin
        if (mem_ack) begin
          if (mem_err) begin
            r_d.err[ERR_FETCH] = 1'b1; // [R17]
            r_d.st = S_DONE;
          end else begin
            r_d.wbuf = mem_rdata;
            r_d.addr = r_q.addr + 16'h1;
            r_d.txb  = mem_rdata[7:0]; // [R19]
            r_d.st   = (r_q.idx == 16'h0) ? S_CHKNODE : S_TXLO;
          end
        end
      end
      S_CHKNODE: begin
        r_d.macid = r_q.wbuf[7:0];  // [R1]
        r_d.svc   = r_q.wbuf[15:8]; // [R1]
        if (r_q.wbuf[7:0] >= 8'(MACID_LIMIT)) begin // [R16]
          r_d.err[ERR_MACID] = 1'b1; // [R17]
          r_d.st = S_DONE;
        end else if (!node_configured[r_q.wbuf[5:0]]) begin // [R16]
          r_d.err[ERR_NOCFG] = 1'b1;
          r_d.st = S_DONE;
        end else if (!node_online[r_q.wbuf[5:0]]) begin // [R16]
          r_d.err[ERR_OFFLINE] = 1'b1;
          r_d.st = S_DONE;
        end else begin
          r_d.st = S_TXLO;
        end
      end
      // class, instance, attribute and data go out in buffer order
      S_TXLO, S_TXHI: begin // [R2] [R3] [R4]
        if (tx_ready) begin
          r_d.idx = r_q.idx + 16'h1;
          if (r_q.idx + 16'h1 == tx_byte_count_reg) begin // [R5]
            r_d.tmo  = '0;
            r_d.ridx = 16'h0;
            r_d.ovf  = 1'b0;
            r_d.st   = S_WAIT;
          end else if (r_q.st == S_TXLO) begin
            r_d.txb = r_q.wbuf[15:8]; // [R19]
            r_d.st  = S_TXHI;
          end else begin
            r_d.st = S_FETCH;
          end
        end
      end
      S_WAIT: begin
        r_d.tmo = TW'(r_q.tmo + 1'b1);
        if (rx_valid) begin
          r_d.tmo  = '0;
          r_d.ridx = r_q.ridx + 16'h1;
          if (r_q.ridx >= 16'(RX_DEPTH)) begin
            r_d.ovf = 1'b1; // [R18]
          end
          if (r_q.ridx == RP_MACID) begin
            r_d.rmac = rx_data;
          end
          if (r_q.ridx == RP_SERVICE) begin
            r_d.rsvc = rx_data;
          end
          if (r_q.ridx == RP_GENERAL) begin
            r_d.gen = rx_data; // [R11]
          end
          if (r_q.ridx == RP_ADDITIONAL) begin
            r_d.add = rx_data; // [R11]
          end
          if (rx_last) begin
            r_d.st = S_CHKRX;
          end
        end else if (r_q.tmo == TW'(TIMEOUT_CYC - 1)) begin
          r_d.err[ERR_TIMEOUT] = 1'b1; // [R17]
          r_d.st = S_DONE;
        end
      end
      S_CHKRX: begin
        if (r_q.ovf || rx_total > 17'(rx_buffer_size_reg)) begin
          r_d.err[ERR_OVERRUN] = 1'b1; // [R18]
          r_d.st = S_DONE;
        end else begin
          if (r_q.rsvc == SVC_ERROR) begin // [R9]
            r_d.rerr = 1'b1; // [R10]
          end
          r_d.addr = rx_buffer_start_reg;
          r_d.wbuf = rx_total[15:0]; // [R6]
          r_d.idx  = 16'h0;
          r_d.st   = S_PUT;
        end
      end
      S_PUT: begin
        if (mem_ack) begin
          if (mem_err) begin
            r_d.err[ERR_STORE] = 1'b1; // [R17]
            r_d.st = S_DONE;
          end else begin
            r_d.addr = r_q.addr + 16'h1;
            r_d.st   = (r_q.idx >= r_q.ridx) ? S_DONE : S_RDLO;
          end
        end
      end
      S_RDLO: begin
        r_d.st = S_RDHI;
      end
      S_RDHI: begin
        r_d.lo = ram_rdata;
        r_d.st = S_PACK;
      end
      S_PACK: begin
        // macid then service, then any node data, two bytes a word
        r_d.wbuf = {(r_q.idx + 16'h1 < r_q.ridx) ? ram_rdata : 8'h00,
                    r_q.lo}; // [R6] [R8] [R19]
        r_d.idx  = r_q.idx + 16'h2;
        r_d.st   = S_PUT;
      end
      S_DONE: begin
        // bad echo is raised with complete, once the reply is stored
        if (r_q.err == '0 && !r_q.rerr
            && r_q.rsvc != (r_q.svc | SVC_RESPONSE_BIT)) begin // [R7]
          r_d.err[ERR_OTHER] = 1'b1;
        end
        r_d.done = 1'b1; // [R17]
        r_d.st   = S_IDLE;
      end
      default: begin
        r_d.st = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_q <= '{st: S_IDLE, default: '0};
    end else begin
      r_q <= r_d;
    end
  end

  assign mem_req         = (r_q.st == S_FETCH) || (r_q.st == S_PUT);
  assign mem_we          = (r_q.st == S_PUT);
  assign mem_addr        = r_q.addr;
  assign mem_wdata       = r_q.wbuf;
  assign tx_valid        = (r_q.st == S_TXLO) || (r_q.st == S_TXHI);
  assign tx_data         = r_q.txb;
  assign tx_last         = tx_valid
                           && (r_q.idx + 16'h1 == tx_byte_count_reg);
  assign link_bit_rate   = r_q.rate;
  assign scan_macid      = r_q.scan;
  assign scan_strobe     = r_q.sstb;
  assign xfer_done       = r_q.done;
  assign xfer_error      = r_q.err;
  assign reply_error     = r_q.rerr;
  assign vendor_error    = r_q.rerr && (r_q.gen >= VENDOR_ERR_LO); // [R11]
  assign reply_macid     = r_q.rmac;
  assign general_code    = r_q.gen;
  assign additional_code = r_q.add;
endmodule
`default_nettype wire

// >>> explicit_exchange_checker.sv
// assertions on the exchange block's host, link and status ports
// assumes one clock domain and an active-low asynchronous reset
`timescale 1ns/100ps
`default_nettype none
module explicit_exchange_checker
  import explicit_exchange_pkg::*;
(
  input wire logic             clk,
  input wire logic             rst_n,
  input wire logic             mem_req,
  input wire logic             mem_we,
  input wire logic [15:0]      mem_addr,
  input wire logic             mem_ack,
  input wire logic             tx_valid,
  input wire logic [7:0]       tx_data,
  input wire logic             tx_ready,
  input wire logic [1:0]       bit_rate_sel,
  input wire logic [1:0]       link_bit_rate,
  input wire logic [5:0]       scan_macid,
  input wire logic             xfer_done,
  input wire logic [ERR_W-1:0] xfer_error,
  input wire logic             reply_error,
  input wire logic             vendor_error,
  input wire logic [7:0]       general_code
);
  import explicit_exchange_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_RATE: assert property ($past(rst_n) |->
    link_bit_rate == $past(bit_rate_sel)) else $error("link rate off");
  AST_SCAN: assert property ($changed(scan_macid) |->
    scan_macid == $past(scan_macid) + 6'h1) else $error("scan order");
  AST_TX_HOLD: assert property (tx_valid && !tx_ready |=>
    tx_valid && $stable(tx_data)) else $error("tx byte dropped");
  AST_MEM_HOLD: assert property (mem_req && !mem_ack |=>
    mem_req && $stable(mem_addr) && $stable(mem_we))
    else $error("host access dropped");
  AST_ONE_ERR: assert property ($rose(xfer_done) |->
    $onehot0(xfer_error)) else $error("several error bits");
  AST_ERR_DONE: assert property ($rose(|xfer_error) |->
    ##[0:2] xfer_done) else $error("error without complete");
  AST_VENDOR: assert property (vendor_error |->
    reply_error && general_code >= 8'hd0) else $error("vendor flag");
  AST_ECHO: assert property (reply_error |->
    !xfer_error[ERR_OTHER]) else $error("error reply as bad echo");
  AST_NO_STORE: assert property (xfer_error[ERR_OVERRUN] |->
    !(mem_req && mem_we)) else $error("overrun reply stored");
  AST_IDLE_DONE: assert property (xfer_done |->
    !tx_valid && !mem_req) else $error("busy after complete");
endmodule
bind explicit_exchange explicit_exchange_checker i_chk (
  .clk, .rst_n, .mem_req, .mem_we, .mem_addr, .mem_ack, .tx_valid,
  .tx_data, .tx_ready, .bit_rate_sel, .link_bit_rate, .scan_macid,
  .xfer_done, .xfer_error, .reply_error, .vendor_error, .general_code
);
`default_nettype wire

// >>> explicit_exchange_pkg.sv
// constants shared by the explicit message exchange block
// assumes a single 250 MHz clock and 16-bit host memory words
package explicit_exchange_pkg;
  localparam int          CLK_MHZ          = 250;
  localparam int          POLL_PERIOD_NS   = 1000;
  localparam int          POLL_CYCLES      = (POLL_PERIOD_NS * CLK_MHZ) / 1000;
  localparam int          REPLY_TIMEOUT_US = 1000;
  localparam int          REPLY_TIMEOUT_CYC = REPLY_TIMEOUT_US * CLK_MHZ;

  localparam int          MACID_LIMIT      = 64;
  localparam logic [15:0] REQ_MIN_BYTES    = 16'h0002;
  localparam logic [16:0] RX_HDR_BYTES     = 17'h00002;
  localparam logic [16:0] RX_MIN_SIZE      = 17'h00002;
  localparam logic [7:0]  SVC_RESPONSE_BIT = 8'h80;
  localparam logic [7:0]  SVC_ERROR        = 8'h94;
  localparam logic [7:0]  VENDOR_ERR_LO    = 8'hd0;

  // byte positions within the reply as it arrives from the node
  localparam logic [15:0] RP_MACID         = 16'h0000;
  localparam logic [15:0] RP_SERVICE       = 16'h0001;
  localparam logic [15:0] RP_GENERAL       = 16'h0002;
  localparam logic [15:0] RP_ADDITIONAL    = 16'h0003;

  // completion error flags
  localparam int          ERR_W            = 9;
  localparam int          ERR_ALLOC        = 0;
  localparam int          ERR_FETCH        = 1;
  localparam int          ERR_MACID        = 2;
  localparam int          ERR_NOCFG        = 3;
  localparam int          ERR_OFFLINE      = 4;
  localparam int          ERR_TIMEOUT      = 5;
  localparam int          ERR_OTHER        = 6;
  localparam int          ERR_OVERRUN      = 7;
  localparam int          ERR_STORE        = 8;

  typedef enum logic [3:0] {
    S_IDLE    = 4'b0000,
    S_CHKREG  = 4'b0001,
    S_FETCH   = 4'b0010,
    S_CHKNODE = 4'b0011,
    S_TXLO    = 4'b0100,
    S_TXHI    = 4'b0101,
    S_WAIT    = 4'b0110,
    S_CHKRX   = 4'b0111,
    S_RDLO    = 4'b1000,
    S_RDHI    = 4'b1001,
    S_PACK    = 4'b1010,
    S_PUT     = 4'b1011,
    S_DONE    = 4'b1100
  } state_t;
endpackage

// >>> explicit_exchange_tb_top.sv
// bench for the exchange block with host memory and a remote node
// assumes request buffer at word 16, reply buffer at word 64
`timescale 1ns/100ps
`default_nettype none
module explicit_exchange_tb_top;
  import explicit_exchange_pkg::*;
  logic             clk, rst_n, send_cmd, mem_req, mem_we, mem_ack;
  logic             mem_err, tx_valid, tx_last, tx_ready, rx_valid;
  logic             rx_last, scan_strobe, xfer_done, reply_error;
  logic             vendor_error;
  logic [15:0]      tx_buffer_start_reg, tx_byte_count_reg;
  logic [15:0]      rx_buffer_start_reg, rx_buffer_size_reg;
  logic [15:0]      mem_addr, mem_wdata, mem_rdata;
  logic [63:0]      node_configured, node_online;
  logic [7:0]       tx_data, rx_data, reply_macid, general_code;
  logic [7:0]       additional_code;
  logic [1:0]       bit_rate_sel, link_bit_rate;
  logic [5:0]       scan_macid;
  logic [ERR_W-1:0] xfer_error;
  logic [15:0]      mem [256];
  logic [1:0]       fail;
  int               mismatches, n_checks;
  explicit_exchange #(.MEM_WORDS(256), .TIMEOUT_CYC(50)) i_dut (
    .clk, .rst_n, .send_cmd, .tx_buffer_start_reg, .tx_byte_count_reg,
    .rx_buffer_start_reg, .rx_buffer_size_reg, .mem_req, .mem_we,
    .mem_addr, .mem_wdata, .mem_ack, .mem_err, .mem_rdata,
    .node_configured, .node_online, .tx_valid, .tx_data, .tx_last,
    .tx_ready, .rx_valid, .rx_data, .rx_last, .bit_rate_sel,
    .link_bit_rate, .scan_macid, .scan_strobe, .xfer_done, .xfer_error,
    .reply_error, .vendor_error, .reply_macid, .general_code,
    .additional_code);
  remote_node_model i_node (.clk, .tx_valid, .tx_data, .tx_last,
    .tx_ready, .rx_valid, .rx_data, .rx_last);
  always #2 clk = ~clk;
  // host memory answers each access one cycle later
  always @(posedge clk) begin
    #1 mem_ack = mem_req & ~mem_ack;
    mem_err = mem_ack & fail[mem_we];
    if (mem_ack & mem_we & ~mem_err) mem[mem_addr[7:0]] = mem_wdata;
    mem_rdata = mem_ack ? mem[mem_addr[7:0]] : ~mem_rdata;
  end
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic close_out();
    if (mismatches == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic req(input logic [71:0] b);
    for (int i = 0; i < 5; i++) mem[16 + i] = b[16*i +: 16];
  endtask
  task automatic rep(input logic [31:0] b, input int n);
    for (int i = 0; i < 4; i++) i_node.rp[i] = b[8*i +: 8];
    i_node.rp_n = n;
  endtask
  task automatic run(input logic [15:0] n, input logic [15:0] sz);
    int t;
    repeat (3) tick();
    i_node.rq_n = 0;
    tx_byte_count_reg = n;
    rx_buffer_size_reg = sz;
    send_cmd = 1'b1;
    for (t = 0; t < 2000 && xfer_done !== 1'b0; t++) tick();
    for (t = t; t < 2000 && xfer_done !== 1'b1; t++) tick();
    chk({15'h0, xfer_done}, 16'h0001);
    send_cmd = 1'b0;
  endtask
  task automatic s_set();
    logic [71:0] b;
    b = 72'h03_e8_07_00_02_00_05_10_03;
    req(b);
    rep(32'hbbaa9003, 4);
    i_node.slow = 1'b1;
    run(16'h0009, 16'h0014);
    for (int i = 0; i < 9; i++) chk(i_node.rq[i], b[8*i +: 8]);
    chk(i_node.rq_n[15:0], 16'h0009);
    chk(mem[64], 16'h0006);
    chk(mem[65], 16'h9003);
    chk(mem[66], 16'hbbaa);
    chk({7'h0, xfer_error}, 16'h0000);
    chk(reply_macid, 16'h0003);
    chk(link_bit_rate, 16'h0002);
    i_node.slow = 1'b0;
  endtask
  task automatic s_err();
    logic [7:0] g;
    req(72'h00_00_07_00_02_00_05_0e_03);
    for (int i = 0; i < 2; i++) begin
      g = i ? 8'hd0 : 8'hcf;
      rep({8'hff, g, 16'h9403}, 4);
      run(16'h0007, 16'h0014);
      chk(reply_error, 16'h0001);
      chk(vendor_error, i[15:0]);
      chk(general_code, g);
      chk(additional_code, 16'h00ff);
      chk(mem[66], {8'hff, g});
      chk({7'h0, xfer_error}, 16'h0000);
    end
  endtask
  task automatic s_faults();
    int mid[8] = '{64, 5, 6, 3, 3, 3, 3, 3};
    int cnt[8] = '{7, 7, 7, 1, 7, 7, 7, 7};
    int sz[8]  = '{20, 20, 20, 20, 5, 20, 20, 20};
    int rn[8]  = '{4, 4, 4, 4, 4, 0, 4, 4};
    int fl[8]  = '{0, 0, 0, 0, 0, 0, 1, 2};
    int eb[8]  = '{ERR_MACID, ERR_NOCFG, ERR_OFFLINE, ERR_ALLOC,
                   ERR_OVERRUN, ERR_TIMEOUT, ERR_FETCH, ERR_STORE};
    for (int k = 0; k < 8; k++) begin
      mem[64] = 16'h0000;
      req({16'h0, 48'h07_00_02_00_05_10, mid[k][7:0]});
      rep(32'hbbaa9003, rn[k]);
      fail = fl[k][1:0];
      run(cnt[k][15:0], sz[k][15:0]);
      fail = 2'b00;
      chk({7'h0, xfer_error}, 16'h0001 << eb[k]);
      chk(mem[64], 16'h0000);
      chk(xfer_done, 16'h0001);
    end
  endtask
  task automatic s_echo();
    req({16'h0, 48'h07_00_02_00_05_10, 8'h03});
    rep(32'hbbaa9103, 4);
    run(16'h0007, 16'h0014);
    chk({7'h0, xfer_error}, 16'h0001 << ERR_OTHER);
    chk(reply_error, 16'h0000);
    chk(mem[64], 16'h0006);
    chk(mem[65], 16'h9103);
  endtask
  task automatic s_scan();
    int n;
    n = 0;
    while (n < 20000 && !(scan_strobe === 1'b1 && scan_macid == 6'h03)) begin
      tick();
      n++;
    end
    chk({10'h0, scan_macid}, 16'h0003);
    n = 0;
    do begin
      tick();
      n++;
    end while (n < 2000 && scan_strobe !== 1'b1);
    chk(n[15:0], 16'(3 * POLL_CYCLES));
    chk({10'h0, scan_macid}, 16'h0006);
  endtask
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    send_cmd = 1'b0;
    fail = 2'b00;
    bit_rate_sel = 2'h2;
    tx_buffer_start_reg = 16'h0010;
    rx_buffer_start_reg = 16'h0040;
    tx_byte_count_reg = 16'h0000;
    rx_buffer_size_reg = 16'h0000;
    node_configured = 64'h48;
    node_online = 64'h08;
    mismatches = 0;
    n_checks = 0;
    repeat (4) @(posedge clk);
    #1 rst_n = 1'b1;
    s_set();
    s_err();
    s_faults();
    s_echo();
    s_scan();
    close_out();
  end
  initial begin
    #200000;
    mismatches++;
    close_out();
  end
endmodule
`default_nettype wire

// >>> remote_node_model.sv
// remote node: captures request bytes, answers with a preset reply
// assumes the bench fills rp and rp_n before each transaction
`timescale 1ns/100ps
`default_nettype none
module remote_node_model (
  input  wire logic       clk,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_last,
  output logic            tx_ready,
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  output logic            rx_last
);
  logic [7:0] rq [16];
  logic [7:0] rp [16];
  int         rq_n;
  int         rp_n;
  logic       slow;
  initial begin
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    rx_last  = 1'b0;
    rq_n     = 0;
    rp_n     = 0;
    slow     = 1'b0;
  end
  // same bit rate assumed on both ends, one byte per beat
  always begin
    @(posedge clk);
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      rq[rq_n] = tx_data;
      rq_n++;
      if (tx_last === 1'b1) begin
        #1 tx_ready = 1'b0;
        repeat (3) @(posedge clk);
        // reply sends the preset rp bytes in order, macid first as the bench loads it
        for (int i = 0; i < rp_n; i++) begin
          #1 rx_valid = 1'b1;
          rx_data = rp[i];
          rx_last = (i == rp_n - 1);
          @(posedge clk);
        end
        #1 rx_valid = 1'b0;
        rx_last = 1'b0;
        rx_data = ~rx_data;
      end else begin
        #1;
      end
    end else begin
      #1;
    end
    tx_ready = slow ? ~tx_ready : 1'b1;
  end
endmodule
`default_nettype wire

// >>> reply_byte_ram.sv
// byte memory that holds one reply while it is checked
// assumes read address is presented one cycle before the data is used
`timescale 1ns/100ps
`default_nettype none
module reply_byte_ram #(
  parameter int DEPTH = 256,
  parameter int AW    = 8
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [7:0]    wdata,
  input  wire logic [AW-1:0] raddr,
  output logic      [7:0]    rdata_q
);
  logic [7:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= mem[raddr];
    end
  end
endmodule
`default_nettype wire
